// ---- design/ubi_pkg.sv ----
// Package for the serial port low control bits, baud generator and infrared path.
// Assumes an APB master with 32-bit data and a single clock and reset.
package ubi_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam int unsigned ADDR_LSB_W = 8;
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RXEN = 8'h08;
  localparam logic [7:0] OFS_BAUD_HI = 8'h0C;
  localparam logic [7:0] OFS_BAUD_LO = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

  // ********************************
  // Field values and reset values
  // ********************************
  localparam logic [2:0] SEL_MULTIPROC = 3'h0;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [7:0] RELOAD_HI_RST = 8'h00;
  localparam logic [7:0] RELOAD_LO_RST = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // ********************************
  // Infrared timing in baud ticks
  // ********************************
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [3:0] IR_PERIOD_LAST = 4'hF;
  localparam logic [3:0] IR_PHASE_ZERO = 4'h0;
  localparam logic [3:0] IR_PHASE_STEP = 4'h1;

  // Low three bits of the multiprocessor control register, bit 2 down to bit 0.
  typedef struct packed {
    logic baud_gen_control_bit;
    logic rx_data_irq_mask_bit;
    logic infrared_enable_bit;
  } ubi_ctrl_t;

  // Sticky event bits, bit 2 down to bit 0.
  typedef struct packed {
    logic rx_err;
    logic rx_data;
    logic baud_zero;
  } ubi_irq_t;

  localparam ubi_ctrl_t CTRL_RST = 3'h0;
  localparam ubi_irq_t IRQ_RST = 3'h0;

endpackage

// ---- design/ubi_ctrl.sv ----
// Low control bits of the shared serial control register, with the baud rate
// generator, receive interrupt masking and infrared encoder/decoder they steer.
// Assumes an APB master, a serial core on the same clock and one serial pin pair.
//
// Notes on behaviour
// - Control bit meaning depends on receiver enable.
// - Receiver off, bit 0: stopped, reload readback.
// - Receiver off, bit 1: counts, interrupts at zero.
// - Receiver off, bit 1: high byte reads count.
// - Receiver on, bit 0: both bytes read reload.
// - Receiver on, bit 1: both bytes read count.
// - No high byte snapshot on low read.
// - Mask 0: data and errors both interrupt.
// - Mask 1: data events do not interrupt; errors still do.
// - Infrared off: normal serial path used.
// - Infrared on: data passes infrared codec.
// - Bits reachable only with select field 000b.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
module ubi_ctrl #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial core side.
  input wire logic core_txd,
  input wire logic rx_data_evt,
  input wire logic rx_err_evt,
  output logic core_rxd,
  output logic baud_tick,
  // Pins and interrupt.
  input wire logic serial_rxd_pin,
  output logic serial_txd_pin,
  output logic irq
);

  if (ADDR_W < ubi_pkg::ADDR_LSB_W) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // Address match against one register offset; upper address bits must be zero.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // ********************************
  // Register state and APB slave
  // ********************************
  logic [2:0] reg_sel;
  logic [2:0] next_reg_sel;
  ubi_pkg::ubi_ctrl_t ctrl;
  ubi_pkg::ubi_ctrl_t next_ctrl;
  logic rx_en;
  logic next_rx_en;
  logic [7:0] reload_hi;
  logic [7:0] next_reload_hi;
  logic [7:0] reload_lo;
  logic [7:0] next_reload_lo;
  ubi_pkg::ubi_irq_t irq_en;
  ubi_pkg::ubi_irq_t next_irq_en;
  ubi_pkg::ubi_irq_t irq_stat;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [15:0] count;
  logic wr_fire, rd_setup, mapped;
  logic [15:0] reload;
  logic [7:0] baud_hi_view, baud_lo_view;
  ubi_pkg::ubi_irq_t clr_mask;

  assign reload = {reload_hi, reload_lo};
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_setup = psel & penable & ~pready;

  // Readback of the baud bytes; the live count is sampled per byte with no latch.
  always_comb begin
    if (rx_en) begin
      baud_hi_view = ctrl.baud_gen_control_bit ? count[15:8] : reload_hi;
      baud_lo_view = ctrl.baud_gen_control_bit ? count[7:0] : reload_lo;
    end else begin
      baud_hi_view = ctrl.baud_gen_control_bit ? count[15:8] : reload_hi;
      baud_lo_view = reload_lo;
    end
  end

  // One wait state per transfer gives the readback a registered path.
  always_comb begin
    next_reg_sel = reg_sel;
    next_ctrl = ctrl;
    next_rx_en = rx_en;
    next_reload_hi = reload_hi;
    next_reload_lo = reload_lo;
    next_irq_en = irq_en;
    clr_mask = ubi_pkg::IRQ_RST;
    next_prdata = prdata;
    next_pready = rd_setup;
    next_pslverr = 1'b0;
    mapped = hit(paddr, ubi_pkg::OFS_SELECT) | hit(paddr, ubi_pkg::OFS_CTRL1)
           | hit(paddr, ubi_pkg::OFS_RXEN) | hit(paddr, ubi_pkg::OFS_BAUD_HI)
           | hit(paddr, ubi_pkg::OFS_BAUD_LO) | hit(paddr, ubi_pkg::OFS_IRQ_STAT)
           | hit(paddr, ubi_pkg::OFS_IRQ_CLR) | hit(paddr, ubi_pkg::OFS_IRQ_EN);
    if (rd_setup) begin
      next_pslverr = ~mapped;
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hit(paddr, ubi_pkg::OFS_SELECT): next_prdata[2:0] = reg_sel;
          hit(paddr, ubi_pkg::OFS_CTRL1): begin
            if (reg_sel == ubi_pkg::SEL_MULTIPROC) begin
              next_prdata[2:0] = ctrl;
            end
          end
          hit(paddr, ubi_pkg::OFS_RXEN): next_prdata[0] = rx_en;
          hit(paddr, ubi_pkg::OFS_BAUD_HI): next_prdata[7:0] = baud_hi_view;
          hit(paddr, ubi_pkg::OFS_BAUD_LO): next_prdata[7:0] = baud_lo_view;
          hit(paddr, ubi_pkg::OFS_IRQ_STAT): next_prdata[2:0] = irq_stat;
          hit(paddr, ubi_pkg::OFS_IRQ_EN): next_prdata[2:0] = irq_en;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_fire && pstrb[0]) begin
      if (hit(paddr, ubi_pkg::OFS_SELECT)) begin
        next_reg_sel = pwdata[2:0];
      end
      if (hit(paddr, ubi_pkg::OFS_CTRL1) && reg_sel == ubi_pkg::SEL_MULTIPROC) begin
        next_ctrl = pwdata[2:0];
      end
      if (hit(paddr, ubi_pkg::OFS_RXEN)) begin
        next_rx_en = pwdata[0];
      end
      if (hit(paddr, ubi_pkg::OFS_BAUD_HI)) begin
        next_reload_hi = pwdata[7:0];
      end
      if (hit(paddr, ubi_pkg::OFS_BAUD_LO)) begin
        next_reload_lo = pwdata[7:0];
      end
      if (hit(paddr, ubi_pkg::OFS_IRQ_CLR)) begin
        clr_mask = pwdata[2:0];
      end
      if (hit(paddr, ubi_pkg::OFS_IRQ_EN)) begin
        next_irq_en = pwdata[2:0];
      end
    end
  end

  // Register file flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_sel <= ubi_pkg::SEL_RST;
      ctrl <= ubi_pkg::CTRL_RST;
      rx_en <= 1'b0;
      reload_hi <= ubi_pkg::RELOAD_HI_RST;
      reload_lo <= ubi_pkg::RELOAD_LO_RST;
      irq_en <= ubi_pkg::IRQ_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      reg_sel <= next_reg_sel;
      ctrl <= next_ctrl;
      rx_en <= next_rx_en;
      reload_hi <= next_reload_hi;
      reload_lo <= next_reload_lo;
      irq_en <= next_irq_en;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ********************************
  // Baud rate generator
  // ********************************
  logic [15:0] next_count;
  logic next_baud_tick;
  logic run;

  // The receiver needs the generator, so it runs whenever the receiver is on.
  assign run = rx_en | ctrl.baud_gen_control_bit;

  // Down counter; while stopped it tracks the reload so a restart is clean.
  always_comb begin
    next_baud_tick = 1'b0;
    if (!run) begin
      next_count = reload;
    end else if (count == ubi_pkg::COUNT_ZERO) begin
      next_count = reload;
      next_baud_tick = 1'b1;
    end else begin
      next_count = count - ubi_pkg::COUNT_STEP;
    end
  end

  // Generator flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= ubi_pkg::COUNT_ZERO;
      baud_tick <= 1'b0;
    end else begin
      count <= next_count;
      baud_tick <= next_baud_tick;
    end
  end

  // ********************************
  // Interrupt status
  // ********************************
  ubi_pkg::ubi_irq_t next_irq_stat;
  ubi_pkg::ubi_irq_t set_mask;
  logic next_irq;

  // Events set sticky bits; a set in the clearing cycle wins.
  always_comb begin
    set_mask.baud_zero = next_baud_tick & ~rx_en & ctrl.baud_gen_control_bit;
    set_mask.rx_data = rx_data_evt & ~ctrl.rx_data_irq_mask_bit;
    set_mask.rx_err = rx_err_evt;
    next_irq_stat = set_mask | (irq_stat & ~clr_mask);
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // Status flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat <= ubi_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= next_irq;
    end
  end

  // ********************************
  // Infrared encoder/decoder
  // ********************************
  logic rx_meta, rx_sync;
  logic [3:0] tx_phase;
  logic [3:0] next_tx_phase;
  logic [3:0] rx_hold;
  logic [3:0] next_rx_hold;
  logic next_serial_txd_pin, next_core_rxd;

  // A zero bit is sent as a short high pulse at the start of each bit period.
  always_comb begin
    next_tx_phase = tx_phase;
    next_rx_hold = rx_hold;
    if (core_txd) begin
      next_tx_phase = ubi_pkg::IR_PHASE_ZERO;
    end else if (baud_tick) begin
      next_tx_phase = tx_phase + ubi_pkg::IR_PHASE_STEP;
    end
    if (rx_sync) begin
      next_rx_hold = ubi_pkg::IR_PERIOD_LAST;
    end else if (baud_tick && rx_hold != ubi_pkg::IR_PHASE_ZERO) begin
      next_rx_hold = rx_hold - ubi_pkg::IR_PHASE_STEP;
    end
    if (ctrl.infrared_enable_bit) begin
      next_serial_txd_pin = ~core_txd & (tx_phase < ubi_pkg::IR_PULSE_TICKS);
      next_core_rxd = ~rx_sync & (rx_hold == ubi_pkg::IR_PHASE_ZERO);
    end else begin
      next_serial_txd_pin = core_txd;
      next_core_rxd = rx_sync;
    end
  end

  // Pin synchroniser and codec flops; the pins idle high in normal mode.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      tx_phase <= ubi_pkg::IR_PHASE_ZERO;
      rx_hold <= ubi_pkg::IR_PHASE_ZERO;
      serial_txd_pin <= 1'b1;
      core_rxd <= 1'b1;
    end else begin
      rx_meta <= serial_rxd_pin;
      rx_sync <= rx_meta;
      tx_phase <= next_tx_phase;
      rx_hold <= next_rx_hold;
      serial_txd_pin <= next_serial_txd_pin;
      core_rxd <= next_core_rxd;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  sequence rd_hi_s;
    rd_setup && !pwrite && hit(paddr, ubi_pkg::OFS_BAUD_HI);
  endsequence
  sequence rd_lo_s;
    rd_setup && !pwrite && hit(paddr, ubi_pkg::OFS_BAUD_LO);
  endsequence

  ctrl_reset_a: assert property (@(posedge ref_clk) reset |=> ctrl == ubi_pkg::CTRL_RST)
    else $error("control bits not cleared by reset");
  stop_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !rx_en && !ctrl.baud_gen_control_bit ##1 !rx_en && !ctrl.baud_gen_control_bit
    |-> count == $past(reload) && !baud_tick)
    else $error("stopped generator moved");
  zero_irq_a: assert property (@(posedge ref_clk) disable iff (reset)
    run && !rx_en && ctrl.baud_gen_control_bit && count == ubi_pkg::COUNT_ZERO
    |=> irq_stat.baud_zero && baud_tick)
    else $error("zero count did not raise event");
  live_hi_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_hi_s and (!rx_en && ctrl.baud_gen_control_bit) |=> prdata[7:0] == $past(count[15:8]))
    else $error("high byte not live count");
  reload_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_lo_s and (rx_en && !ctrl.baud_gen_control_bit) |=> prdata[7:0] == $past(reload_lo))
    else $error("low byte not reload");
  live_lo_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_lo_s and (rx_en && ctrl.baud_gen_control_bit) |=> prdata[7:0] == $past(count[7:0]))
    else $error("low byte not live count");
  data_irq_a: assert property (@(posedge ref_clk) disable iff (reset)
    rx_data_evt && !ctrl.rx_data_irq_mask_bit |=> irq_stat.rx_data)
    else $error("unmasked data event lost");
  data_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
    rx_data_evt && ctrl.rx_data_irq_mask_bit && !irq_stat.rx_data |=> !irq_stat.rx_data)
    else $error("masked data event set status");
  ir_bypass_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ctrl.infrared_enable_bit |=> serial_txd_pin == $past(core_txd))
    else $error("bypass path broken");
  ir_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    ctrl.infrared_enable_bit && core_txd |=> !serial_txd_pin)
    else $error("encoder pulsed on a one bit");
  sel_guard_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_fire && reg_sel != ubi_pkg::SEL_MULTIPROC |=> $stable(ctrl))
    else $error("control changed under other select");

endmodule

// ---- bench/ubi_far_node.sv ----
// Far-side serial node that answers whatever the block sends on its transmit pin.
// Assumes the same clock as the block; it has no reset of its own.
`timescale 1ns/10ps
module ubi_far_node (
  // Clock.
  input wire logic ref_clk,
  // Serial line from and to the block.
  input wire logic tx_line,
  output logic rx_line
);
  // ********************************
  // Echo path
  // ********************************
  // The remote end echoes each level one cycle later, so any pulse that the infrared
  // encoder sends comes back as a pulse to its decoder. It idles high like a plain line.
  initial rx_line = 1'b1;
  always @(posedge ref_clk) begin
    rx_line <= tx_line;
  end
endmodule

// ---- bench/tb_uart_baud_irq_infrared_control.sv ----
// Self-checking bench for the serial port low control bits and what they steer.
// Assumes the design package and module are compiled first; one clock, sync reset.
`timescale 1ns/10ps
module tb_uart_baud_irq_infrared_control;
  // ********************************
  // Signals
  // ********************************
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rd2;
  logic pready, pslverr, err, core_rxd, baud_tick, serial_rxd_pin, serial_txd_pin, irq;
  logic core_txd = 1'b1, rx_data_evt = 1'b0, rx_err_evt = 1'b0;
  logic [31:0] seed = 32'h91D74228;
  int n_fail = 0, cmp_count = 0, k, lo;

  // Clock of 8 ns period.
  always #4 ref_clk = ~ref_clk;

  ubi_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_txd(core_txd), .rx_data_evt(rx_data_evt),
    .rx_err_evt(rx_err_evt), .core_rxd(core_rxd), .baud_tick(baud_tick),
    .serial_rxd_pin(serial_rxd_pin), .serial_txd_pin(serial_txd_pin), .irq(irq));
  ubi_far_node FAR (.ref_clk(ref_clk), .tx_line(serial_txd_pin), .rx_line(serial_rxd_pin));

  // ********************************
  // Helpers
  // ********************************
  // Repeatable random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait is bounded because the slave answer time is not assumed.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && t < 20) begin
      @(posedge ref_clk);
      t++;
    end
    if (t == 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle receiver event, data or error.
  task automatic pulse(input logic e);
    @(posedge ref_clk);
    rx_data_evt <= ~e;
    rx_err_evt <= e;
    @(posedge ref_clk);
    rx_data_evt <= 1'b0;
    rx_err_evt <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Cycles between two generator ticks.
  task automatic tick_gap(output int n);
    n = 0;
    while (baud_tick !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    @(posedge ref_clk);
    n++;
    while (baud_tick !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hang of any wait ends the run as a failure.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    close_out;
  end

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, ubi_pkg::OFS_CTRL1, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    // Control bits hide behind a nonzero select value.
    apb(1'b1, ubi_pkg::OFS_SELECT, 32'h1);
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h7);
    apb(1'b0, ubi_pkg::OFS_CTRL1, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, ubi_pkg::OFS_SELECT, 32'h0);
    apb(1'b0, ubi_pkg::OFS_CTRL1, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h7);
    apb(1'b0, ubi_pkg::OFS_CTRL1, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h0);
    // With the generator control bit clear the baud bytes read back the reload in both receiver states.
    for (k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      apb(1'b1, ubi_pkg::OFS_RXEN, k);
      apb(1'b1, ubi_pkg::OFS_BAUD_HI, seed[15:8]);
      apb(1'b1, ubi_pkg::OFS_BAUD_LO, seed[7:0]);
      apb(1'b0, ubi_pkg::OFS_BAUD_HI, 32'h0);
      check(rd, {24'h0, seed[15:8]});
      apb(1'b0, ubi_pkg::OFS_BAUD_LO, 32'h0);
      check(rd, {24'h0, seed[7:0]});
    end
    // Live count from a large reload; it stays well inside one high byte value.
    apb(1'b1, ubi_pkg::OFS_RXEN, 32'h0);
    apb(1'b1, ubi_pkg::OFS_BAUD_HI, 32'h10);
    apb(1'b1, ubi_pkg::OFS_BAUD_LO, 32'h0);
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h4);
    apb(1'b0, ubi_pkg::OFS_BAUD_HI, 32'h0);
    check(rd, 32'h0F);
    apb(1'b1, ubi_pkg::OFS_RXEN, 32'h1);
    apb(1'b0, ubi_pkg::OFS_BAUD_HI, 32'h0);
    check(rd, 32'h0F);
    apb(1'b0, ubi_pkg::OFS_BAUD_LO, 32'h0);
    rd2 = rd;
    apb(1'b0, ubi_pkg::OFS_BAUD_LO, 32'h0);
    check(rd2 - rd, 32'h4);
    // Tick period and zero interrupt with the receiver off.
    seed = lfsr(seed);
    lo = seed[2:0] + 2;
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h0);
    apb(1'b1, ubi_pkg::OFS_RXEN, 32'h0);
    apb(1'b1, ubi_pkg::OFS_BAUD_HI, 32'h0);
    apb(1'b1, ubi_pkg::OFS_BAUD_LO, lo);
    apb(1'b1, ubi_pkg::OFS_IRQ_EN, 32'h1);
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h4);
    tick_gap(k);
    check(k, lo + 1);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, ubi_pkg::OFS_IRQ_STAT, 32'h0);
    check(rd & 32'h1, 32'h1);
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h0);
    apb(1'b1, ubi_pkg::OFS_IRQ_CLR, 32'h7);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    // Data events interrupt only while unmasked; errors always do.
    apb(1'b1, ubi_pkg::OFS_IRQ_EN, 32'h6);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, ubi_pkg::OFS_CTRL1, k * 2);
      pulse(1'b0);
      check({31'h0, irq}, {31'h0, ~k[0]});
      apb(1'b1, ubi_pkg::OFS_IRQ_CLR, 32'h7);
      pulse(1'b1);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, ubi_pkg::OFS_IRQ_CLR, 32'h7);
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq}, 32'h0);
    end
    // Plain and infrared paths, generator ticking every cycle.
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h0);
    apb(1'b1, ubi_pkg::OFS_BAUD_LO, 32'h0);
    apb(1'b1, ubi_pkg::OFS_RXEN, 32'h1);
    for (k = 0; k < 2; k++) begin
      core_txd <= k[0];
      repeat (8) @(posedge ref_clk);
      check({serial_txd_pin, core_rxd}, {30'h0, k[0], k[0]});
    end
    apb(1'b1, ubi_pkg::OFS_CTRL1, 32'h1);
    repeat (8) @(posedge ref_clk);
    check({31'h0, serial_txd_pin}, 32'h0);
    core_txd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    lo = 0;
    repeat (32) begin
      @(posedge ref_clk);
      if (serial_txd_pin === 1'b1) lo++;
    end
    check(lo, 32'h6);
    check({31'h0, core_rxd}, 32'h0);
    core_txd <= 1'b1;
    close_out;
  end
endmodule
